// ===== rtl/serial_pkg.sv
// Shared constants of the serial frame-format port: map, fields, resets.
// Assumes a Wishbone master with 32-bit data and byte addresses.
package serial_pkg;

    // Bit period in timer-0 output pulses
    localparam int unsigned TICKS_PER_BIT = 32;

    // Register byte offsets, one aligned word each
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_TXD = 8'h04;
    localparam logic [7:0] ADR_RXD = 8'h08;
    localparam logic [7:0] ADR_STAT = 8'h0C;
    localparam logic [7:0] ADR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADR_IRQ_MASK = 8'h14;

    // Control field positions
    localparam int CTRL_TX_ON = 4;
    localparam int CTRL_RX_ON = 3;
    localparam int CTRL_PAR_OMIT = 2;
    localparam int CTRL_ODD = 1;
    localparam int CTRL_TWO_STOP = 0;

    // Interrupt event positions and width
    localparam int IRQ_RX = 0;
    localparam int IRQ_TX = 1;
    localparam int IRQ_ERR = 2;
    localparam int IRQ_W = 3;

    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

endpackage

// ===== rtl/tx_framer.sv
// Serialiser: start bit, eight data bits LSB first, optional parity, stops.
// Assumes tick_i is a one-cycle pulse from logic on clk_i.
module tx_framer #(
    parameter int unsigned TICKS = serial_pkg::TICKS_PER_BIT
) (
    // Clock, reset, freeze
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Control
    input wire logic en_i,
    input wire logic tick_i,
    input wire logic load_i,
    input wire logic [7:0] data_i,
    input wire logic parity_omit_i,
    input wire logic odd_i,
    input wire logic two_stop_i,
    // Line and state
    output logic txd_o,
    output logic busy_o
);
    localparam int TW = $clog2(TICKS);

    logic [11:0] frame_reg;
    logic [3:0] left_reg;
    logic [TW-1:0] tick_reg;

    // frame image, parity sense and length
    wire par_bit = ^data_i ^ odd_i;
    wire [11:0] frame_next = {2'b11, parity_omit_i | par_bit, data_i, 1'b0};
    wire [3:0] len_next = 4'ha + {3'b000, ~parity_omit_i} + {3'b000, two_stop_i};
    wire bit_end = tick_i && (tick_reg == TW'(TICKS - 1));
    wire load_go = load_i && !busy_o;

    // shifter idles all ones, line rests high
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            frame_reg <= '1;
            left_reg <= '0;
            tick_reg <= '0;
        end
        else if (ce_i)
        begin
            if (!en_i)
            begin
                frame_reg <= '1;
                left_reg <= '0;
                tick_reg <= '0;
            end
            else if (load_go)
            begin
                frame_reg <= frame_next;
                left_reg <= len_next;
                tick_reg <= '0;
            end
            else if (busy_o && bit_end)
            begin
                frame_reg <= {1'b1, frame_reg[11:1]};
                left_reg <= left_reg - 4'h1;
                tick_reg <= '0;
            end
            else if (busy_o && tick_i)
                tick_reg <= tick_reg + TW'(1);
        end
    end

    assign busy_o = (left_reg != 4'h0);
    assign txd_o = frame_reg[0];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || !ce_i);

    chk_tx_init_idle: assert property (!en_i |=> txd_o && !busy_o)
        else $error("transmitter not idle after disable");
    chk_parity_gen: assert property (en_i && load_go && !parity_omit_i
        |=> frame_reg[9] == (^$past(data_i) ^ $past(odd_i)))
        else $error("parity bit wrong sense");
endmodule // tx_framer

// ===== rtl/rx_deframer.sv
// Deserialiser: finds a start bit, samples mid-bit, checks parity and stop.
// Assumes rxd_i is already synchronised and tick_i is on clk_i.
module rx_deframer #(
    parameter int unsigned TICKS = serial_pkg::TICKS_PER_BIT
) (
    // Clock, reset, freeze
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Control
    input wire logic en_i,
    input wire logic tick_i,
    input wire logic rxd_i,
    input wire logic parity_omit_i,
    input wire logic odd_i,
    // Result
    output logic done_o,
    output logic [7:0] data_o,
    output logic perr_o,
    output logic ferr_o,
    output logic busy_o
);
    localparam int TW = $clog2(TICKS);

    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_START = 3'b010,
        RX_BITS = 3'b100
    } rx_state_t;

    rx_state_t state_reg;
    logic [TW-1:0] tick_reg;
    logic [3:0] cnt_reg;
    logic [8:0] shift_reg;

    wire half = tick_i && (tick_reg == TW'(TICKS / 2 - 1));
    wire full = tick_i && (tick_reg == TW'(TICKS - 1));
    wire [3:0] nbits = 4'h8 + {3'b000, ~parity_omit_i};
    wire [7:0] data_now = parity_omit_i ? shift_reg[8:1] : shift_reg[7:0];

    // Frame sequencer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= RX_IDLE;
            tick_reg <= '0;
            cnt_reg <= '0;
            shift_reg <= '0;
            done_o <= 1'b0;
            data_o <= serial_pkg::BYTE_ZERO;
            perr_o <= 1'b0;
            ferr_o <= 1'b0;
        end
        else if (ce_i)
        begin
            done_o <= 1'b0;
            if (!en_i)
            begin
                state_reg <= RX_IDLE;
                tick_reg <= '0;
            end
            else
            begin
                unique case (state_reg)
                    RX_IDLE:
                    begin
                        tick_reg <= '0;
                        if (tick_i && !rxd_i)
                            state_reg <= RX_START;
                    end
                    RX_START:
                    begin
                        tick_reg <= tick_i ? tick_reg + TW'(1) : tick_reg;
                        if (half)
                        begin
                            tick_reg <= '0;
                            cnt_reg <= '0;
                            state_reg <= rxd_i ? RX_IDLE : RX_BITS;
                        end
                    end
                    RX_BITS:
                    begin
                        tick_reg <= tick_i ? tick_reg + TW'(1) : tick_reg;
                        if (full && cnt_reg < nbits)
                        begin
                            tick_reg <= '0; // No reliance on counter wrap
                            shift_reg <= {rxd_i, shift_reg[8:1]};
                            cnt_reg <= cnt_reg + 4'h1;
                        end
                        else if (full)
                        begin
                            tick_reg <= '0;
                            data_o <= data_now;
                            ferr_o <= !rxd_i;
                            perr_o <= !parity_omit_i && ((^shift_reg) != odd_i);
                            done_o <= 1'b1;
                            state_reg <= RX_IDLE;
                        end
                    end
                    default: state_reg <= RX_IDLE;
                endcase
            end
        end
    end

    assign busy_o = (state_reg != RX_IDLE);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || !ce_i);

    chk_rx_init_idle: assert property (!en_i |=> !busy_o)
        else $error("receiver not idle after disable");
    chk_rx_start_seen: assert property (en_i && !busy_o && tick_i && !rxd_i
        |=> state_reg == RX_START)
        else $error("start bit not taken");
endmodule // rx_deframer

// ===== rtl/uart_frame_ctrl.sv
// Serial port control, frame format, flags and Wishbone register slave.
// Assumes tick_i is the timer-0 output pulse on clk_i; rxd_i is a pin.
//
// How it works
// - Transmit enable bit 4 starts the rate generator, transmitter ready.
// - With transmitter enabled, writing the holding register sends that byte.
// - Clearing transmit enable resets the transmitter, abandoning any frame.
// - Receive enable bit 3 starts the rate generator, receiver ready.
// - With receiver enabled, a low start bit begins reception.
// - Clearing receive enable resets the receiver.
// - Bit 2 low adds and checks parity; high omits it.
// - Bit 1 picks parity sense: low even, high odd.
// - Bit 0 picks one stop bit when low, two when high.
// - Frame is start, data bits 0..7, parity if on, then stops.
// - Control register is 8 bits, readable and writable, returns last write.
// - One bit lasts 32 timer-0 output periods; no other rate source.
// - Stop bit sampled low sets the framing flag.
// - Reception ending while receive-full is set sets the overrun flag.
// - Reading status clears overrun, framing and parity flags; reset too.
module uart_frame_ctrl #(
    parameter int unsigned TICKS_PER_BIT = serial_pkg::TICKS_PER_BIT
) (
    // Clock, reset, freeze
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Rate source
    input wire logic tick_i,
    // Serial line
    input wire logic rxd_i,
    output logic txd_o,
    // Interrupt
    output logic irq_o
);
    // Parameter check
    if (TICKS_PER_BIT < 4 || TICKS_PER_BIT > 256 || TICKS_PER_BIT % 2 != 0)
    begin : g_bad_ticks
        $error("TICKS_PER_BIT must be even and within 4 to 256");
    end

    // Register state
    logic ack_reg;
    logic [31:0] rdat_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] tx_hold_reg;
    logic tx_pend_reg;
    logic [7:0] rx_hold_reg;
    logic rx_full_reg;
    logic ovr_reg;
    logic fe_reg;
    logic pe_reg;
    logic [serial_pkg::IRQ_W-1:0] irq_stat_reg;
    logic [serial_pkg::IRQ_W-1:0] irq_mask_reg;
    logic rxd_meta_reg;
    logic rxd_sync_reg;

    // Sub-block results
    logic tx_busy;
    logic rx_done;
    logic [7:0] rx_data;
    logic rx_perr;
    logic rx_ferr;
    logic rx_busy;

    // Control fields
    wire tx_on = ctrl_reg[serial_pkg::CTRL_TX_ON];
    wire rx_on = ctrl_reg[serial_pkg::CTRL_RX_ON];
    wire par_omit = ctrl_reg[serial_pkg::CTRL_PAR_OMIT];
    wire odd_sel = ctrl_reg[serial_pkg::CTRL_ODD];
    wire two_stop = ctrl_reg[serial_pkg::CTRL_TWO_STOP];

    wire rate_run = tx_on || rx_on;
    wire tick_en = tick_i && rate_run;

    // Bus decode
    wire take = cyc_i && stb_i && !ack_reg;
    wire wr = take && we_i && sel_i[0];
    wire rd = take && !we_i;
    wire hit_ctrl = (adr_i == serial_pkg::ADR_CTRL);
    wire hit_txd = (adr_i == serial_pkg::ADR_TXD);
    wire hit_rxd = (adr_i == serial_pkg::ADR_RXD);
    wire hit_stat = (adr_i == serial_pkg::ADR_STAT);
    wire hit_istat = (adr_i == serial_pkg::ADR_IRQ_STAT);
    wire hit_imask = (adr_i == serial_pkg::ADR_IRQ_MASK);
    wire wr_ctrl = wr && hit_ctrl;
    wire wr_txd = wr && hit_txd;
    wire wr_istat = wr && hit_istat;
    wire wr_imask = wr && hit_imask;
    wire rd_rxd = rd && hit_rxd;
    wire rd_stat = rd && hit_stat;

    // Status image: rx busy, overrun, framing, parity, tx empty, rx full
    wire [7:0] stat_val = {2'b00, rx_busy, ovr_reg, fe_reg, pe_reg,
                           !tx_pend_reg, rx_full_reg};

    // Read selection, unmapped reads as zero
    wire [7:0] rd_byte =
        hit_ctrl ? ctrl_reg :
        hit_rxd ? rx_hold_reg :
        hit_stat ? stat_val :
        hit_istat ? {5'b00000, irq_stat_reg} :
        hit_imask ? {5'b00000, irq_mask_reg} :
        serial_pkg::BYTE_ZERO;

    // holding register moves to the shifter when it is free
    wire tx_load = tx_pend_reg && tx_on && !tx_busy;

    // Interrupt events and clears
    wire rx_err = rx_ferr || (rx_perr && !par_omit) || rx_full_reg;
    wire [serial_pkg::IRQ_W-1:0] irq_ev = {rx_done && rx_err, tx_load, rx_done};
    wire [serial_pkg::IRQ_W-1:0] irq_clr =
        wr_istat ? dat_i[serial_pkg::IRQ_W-1:0] : '0;

    // Pin synchroniser
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rxd_meta_reg <= 1'b1;
            rxd_sync_reg <= 1'b1;
        end
        else if (ce_i)
        begin
            rxd_meta_reg <= rxd_i;
            rxd_sync_reg <= rxd_meta_reg;
        end
    end

    // Bus answer: ack one cycle after the request is taken
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
            rdat_reg <= serial_pkg::WORD_ZERO;
        end
        else if (ce_i)
        begin
            ack_reg <= take;
            if (rd)
                rdat_reg <= {24'h00_0000, rd_byte};
        end
    end

    // control register keeps all eight bits as written
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctrl_reg <= serial_pkg::CTRL_RESET;
        else if (ce_i && wr_ctrl)
            ctrl_reg <= dat_i[7:0];
    end

    // transmit holding register and pending flag
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tx_hold_reg <= serial_pkg::BYTE_ZERO;
            tx_pend_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            if (!tx_on)
                tx_pend_reg <= 1'b0;
            else if (wr_txd)
            begin
                tx_hold_reg <= dat_i[7:0];
                tx_pend_reg <= 1'b1;
            end
            else if (tx_load)
                tx_pend_reg <= 1'b0;
        end
    end

    // Receive buffer, set wins over the clearing read
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_hold_reg <= serial_pkg::BYTE_ZERO;
            rx_full_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            if (rx_done)
            begin
                rx_hold_reg <= rx_data;
                rx_full_reg <= 1'b1;
            end
            else if (rd_rxd)
                rx_full_reg <= 1'b0;
        end
    end

    // error flags, set wins over read clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ovr_reg <= 1'b0;
            fe_reg <= 1'b0;
            pe_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            ovr_reg <= (rx_done && rx_full_reg) || (ovr_reg && !rd_stat);
            fe_reg <= (rx_done && rx_ferr) || (fe_reg && !rd_stat);
            pe_reg <= (rx_done && rx_perr) || (pe_reg && !rd_stat);
        end
    end

    // Interrupt status, write one to clear, event wins
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
        end
        else if (ce_i)
        begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
            if (wr_imask)
                irq_mask_reg <= dat_i[serial_pkg::IRQ_W-1:0];
        end
    end

    assign irq_o = |(irq_stat_reg & irq_mask_reg);
    assign ack_o = ack_reg;
    assign dat_o = rdat_reg;

    // Transmit side
    tx_framer #(
        .TICKS(TICKS_PER_BIT)
    ) u_tx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .en_i(tx_on),
        .tick_i(tick_en),
        .load_i(tx_load),
        .data_i(tx_hold_reg),
        .parity_omit_i(par_omit),
        .odd_i(odd_sel),
        .two_stop_i(two_stop),
        .txd_o(txd_o),
        .busy_o(tx_busy)
    );

    // Receive side
    rx_deframer #(
        .TICKS(TICKS_PER_BIT)
    ) u_rx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .en_i(rx_on),
        .tick_i(tick_en),
        .rxd_i(rxd_sync_reg),
        .parity_omit_i(par_omit),
        .odd_i(odd_sel),
        .done_o(rx_done),
        .data_o(rx_data),
        .perr_o(rx_perr),
        .ferr_o(rx_ferr),
        .busy_o(rx_busy)
    );

    // Checks on the control side
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || !ce_i);

    sequence txd_write_s;
        wr_txd && tx_on && !tx_busy;
    endsequence

    sequence tx_still_on_s;
        tx_on [*2];
    endsequence

    chk_tx_write_start: assert property (txd_write_s ##1 tx_still_on_s |-> tx_busy)
        else $error("written byte did not start a frame");
    chk_ctrl_readback: assert property (wr_ctrl |=> ctrl_reg == $past(dat_i[7:0]))
        else $error("control register lost a write");
    chk_line_rest_high: assert property (!tx_on ##1 !tx_on |-> txd_o)
        else $error("transmit line low while disabled");
    chk_overrun_set: assert property (rx_done && rx_full_reg |=> ovr_reg)
        else $error("overrun not flagged");
    chk_frame_flag: assert property (rx_done && rx_ferr |=> fe_reg)
        else $error("framing error not flagged");
    chk_err_read_clear: assert property (rd_stat && !rx_done
        |=> !ovr_reg && !fe_reg && !pe_reg)
        else $error("error flags survived status read");
    chk_rate_stopped: assert property (!rate_run |-> !tick_en ##1 !tx_busy)
        else $error("bit rate ran with both sides off");
endmodule // uart_frame_ctrl

// ===== bench/serial_peer.sv
// Remote serial device: drives frames onto rxd, captures frames from txd.
// Assumes a fixed bit time in clk cycles; the bench supplies frame bits.
module serial_peer #(
    parameter int BIT_CYC = 8
) (
    // Clock and lines
    input wire logic clk_i,
    input wire logic txd_i,
    output logic rxd_o
);
    timeunit 1ns;
    timeprecision 1ps;

    int cyc_cnt = 0;

    // Free cycle count for frame spacing
    always @(posedge clk_i)
        cyc_cnt <= cyc_cnt + 1;

    // Line rests at mark level
    initial rxd_o = 1'b1;

    // start, data LSB first, parity, stops
    task automatic send(input logic [11:0] f, input int len);
        for (int i = 0; i < len; i++)
        begin
            rxd_o <= f[i];
            repeat (BIT_CYC) @(posedge clk_i);
        end
        rxd_o <= 1'b1;
        @(posedge clk_i);
    endtask

    // sample each bit mid-period after the start edge
    task automatic recv(input int len, output logic [11:0] bits, output int t0);
        int n;
        n = 0;
        while (txd_i !== 1'b0 && n < 400)
        begin
            @(posedge clk_i);
            n++;
        end
        t0 = cyc_cnt;
        bits = 12'hFFF;
        repeat (BIT_CYC / 2) @(posedge clk_i);
        for (int i = 0; i < len; i++)
        begin
            if (i > 0)
                repeat (BIT_CYC) @(posedge clk_i);
            bits[i] = txd_i;
        end
    endtask
endmodule // serial_peer

// ===== bench/tb_top.sv
// Register-level bench of the serial port: Wishbone tasks, peer frames.
// Assumes the peer model and the design package are compiled first.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TPB = 4;
    localparam int BIT_CYC = 2 * TPB;

    logic clk_i = 0, rst_i = 1, ce_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, tick_i = 0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [31:0] dat_o;
    logic ack_o, txd_o, irq_o, rxd;
    logic [11:0] f;
    int failures = 0, n_compared = 0, cycles = 0;

    uart_frame_ctrl #(.TICKS_PER_BIT(TPB)) DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .tick_i(tick_i), .rxd_i(rxd),
        .txd_o(txd_o), .irq_o(irq_o));
    serial_peer #(.BIT_CYC(BIT_CYC)) peer (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd));

    // Clock, 5 ns period
    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end

    // Timer pulse every second cycle, and hang limit
    always @(posedge clk_i)
    begin
        tick_i <= ~tick_i;
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures++;
            final_report();
        end
    end

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string name, input logic [11:0] e, input logic [11:0] g);
        n_compared++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask

    // Classic single Wishbone cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [31:0] q);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'hF;
        dat_i <= {24'h00_0000, d};
        do
        begin
            @(posedge clk_i);
        end
        while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rdc(input string name, input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        wb(1'b0, a, 8'h00, q);
        chk(name, {4'h0, e}, q[11:0]);
    endtask

    task automatic test_end(input string t);
        $display("test %s done", t);
    endtask

    // Expected frame; unused high positions stay at stop level
    function automatic logic [11:0] frame(input logic [7:0] d, input logic pon, input logic odd);
        return pon ? {2'b11, ^d ^ odd, d, 1'b0} : {3'b111, d, 1'b0};
    endfunction

    // Two back-to-back bytes out, captured by the peer
    task automatic txpair(input logic [7:0] d1, input logic [7:0] d2, input logic pon,
        input logic odd, input int len);
        logic [11:0] ra, rb;
        int ta, tb2, gap;
        fork
            begin
                peer.recv(len, ra, ta);
                peer.recv(len, rb, tb2);
            end
            begin
                wr(serial_pkg::ADR_TXD, d1);
                wr(serial_pkg::ADR_TXD, d2);
            end
        join
        gap = tb2 - ta;
        chk("tx frame first", frame(d1, pon, odd), ra);
        chk("tx frame second", frame(d2, pon, odd), rb);
        chk("frame spacing", 12'h001, {11'h000, gap >= len * BIT_CYC - 2
            && gap <= len * BIT_CYC + 4});
    endtask

    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("txd after reset", 12'h001, {11'h000, txd_o});
        rdc("ctrl reset", serial_pkg::ADR_CTRL, serial_pkg::CTRL_RESET);
        rdc("status reset", serial_pkg::ADR_STAT, 8'h02);
        wr(serial_pkg::ADR_CTRL, 8'h1F);
        rdc("ctrl readback", serial_pkg::ADR_CTRL, 8'h1F);
        rdc("tx holding read", serial_pkg::ADR_TXD, 8'h00);
        rdc("unmapped", 8'h20, 8'h00);
        test_end("registers");
        // Every parity and stop combination, both directions
        for (logic [3:0] m = 0; m < 8; m++)
        begin
            wr(serial_pkg::ADR_CTRL, {3'b000, 2'b11, m[2:0]});
            txpair(8'hA5 ^ m, 8'h3C + m, ~m[2], m[1], 10 + !m[2] + m[0]);
            rdc("tx irq", serial_pkg::ADR_IRQ_STAT, (m == 4'h0) ? 8'h02 : 8'h03);
            wr(serial_pkg::ADR_IRQ_STAT, 8'h07);
            peer.send(frame(8'h96 ^ m, ~m[2], m[1]), 10 + !m[2] + m[0]);
            rdc("rx status", serial_pkg::ADR_STAT, 8'h03);
            rdc("rx data", serial_pkg::ADR_RXD, 8'h96 ^ m);
            rdc("rx irq", serial_pkg::ADR_IRQ_STAT, 8'h01);
        end
        test_end("formats");
        // Even parity, one stop: errors, clear on read, interrupt
        wr(serial_pkg::ADR_CTRL, 8'h18);
        wr(serial_pkg::ADR_IRQ_MASK, 8'h04);
        f = frame(8'h5A, 1'b1, 1'b0);
        peer.send(f ^ 12'h200, 11);
        rdc("parity error", serial_pkg::ADR_STAT, 8'h07);
        chk("irq raised", 12'h001, {11'h000, irq_o});
        rdc("status cleared", serial_pkg::ADR_STAT, 8'h03);
        rdc("data kept", serial_pkg::ADR_RXD, 8'h5A);
        wr(serial_pkg::ADR_IRQ_MASK, 8'h00);
        chk("irq masked", 12'h000, {11'h000, irq_o});
        wr(serial_pkg::ADR_IRQ_STAT, 8'h07);
        rdc("irq cleared", serial_pkg::ADR_IRQ_STAT, 8'h00);
        peer.send(f ^ 12'h400, 11);
        // Low stop bit looks like a start until the half-bit recheck
        repeat (BIT_CYC) @(posedge clk_i);
        rdc("framing error", serial_pkg::ADR_STAT, 8'h0B);
        rdc("framed data", serial_pkg::ADR_RXD, 8'h5A);
        peer.send(f, 11);
        peer.send(frame(8'hE1, 1'b1, 1'b0), 11);
        rdc("overrun", serial_pkg::ADR_STAT, 8'h13);
        rdc("overrun irq", serial_pkg::ADR_IRQ_STAT, 8'h05);
        wr(serial_pkg::ADR_IRQ_MASK, 8'h04);
        chk("irq error on", 12'h001, {11'h000, irq_o});
        wr(serial_pkg::ADR_IRQ_STAT, 8'h04);
        chk("irq error off", 12'h000, {11'h000, irq_o});
        rdc("overwritten", serial_pkg::ADR_RXD, 8'hE1);
        test_end("errors");
        // Receiver off ignores a frame
        wr(serial_pkg::ADR_CTRL, 8'h10);
        peer.send(f, 11);
        rdc("rx off", serial_pkg::ADR_STAT, 8'h02);
        // Abandon a frame by clearing the transmit enable
        wr(serial_pkg::ADR_TXD, 8'h00);
        repeat (30) @(posedge clk_i);
        // Freeze mid-frame: the line must hold its data level
        ce_i <= 1'b0;
        repeat (80) @(posedge clk_i);
        chk("txd frozen", 12'h000, {11'h000, txd_o});
        ce_i <= 1'b1;
        wr(serial_pkg::ADR_CTRL, 8'h00);
        repeat (2) @(posedge clk_i);
        chk("txd abandoned", 12'h001, {11'h000, txd_o});
        rdc("tx reset", serial_pkg::ADR_STAT, 8'h02);
        wr(serial_pkg::ADR_TXD, 8'h77);
        repeat (3 * BIT_CYC) @(posedge clk_i);
        chk("txd off idle", 12'h001, {11'h000, txd_o});
        wr(serial_pkg::ADR_CTRL, 8'h14);
        txpair(8'hC3, 8'h81, 1'b0, 1'b0, 10);
        test_end("enables");
        final_report();
    end
endmodule // tb_top
